// [logic/bsc_pkg.sv]
// Purpose: Shared constants and types for the backed-SRAM clock port host
// Assumes: 50 MHz host clock, byte-wide asynchronous memory with clock bytes
// Notes:   Pin timing counts derived from nanosecond figures below
package bsc_pkg;

	// ------------------------------------------------------------------
	// Array geometry and clock byte map
	// ------------------------------------------------------------------
	localparam int         ADDR_W        = 15;
	localparam int         DATA_W        = 8;
	localparam logic [14:0] CLK_CTRL_ADDR = 15'h7FF8;
	localparam logic [14:0] CLK_SEC_ADDR  = 15'h7FF9;
	localparam logic [14:0] CLK_YEAR_ADDR = 15'h7FFF;
	localparam int         CTRL_WRITE_BIT = 7;
	localparam int         CTRL_READ_BIT  = 6;

	// ------------------------------------------------------------------
	// Timing, in ns as printed, then cycles
	// ------------------------------------------------------------------
	localparam int CLK_NS  = 20;
	localparam int RD_NS   = 70;  // Address and enable access
	localparam int WR_NS   = 60;  // Address valid to strobe high
	localparam int CYC_NS  = 70;  // Least cycle time
	localparam int RD_CYC  = (RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int WR_CYC  = (WR_NS + CLK_NS - 1) / CLK_NS;
	localparam int GAP_CYC = (CYC_NS + CLK_NS - 1) / (2 * CLK_NS);
	localparam logic [2:0] RD_LOAD  = 3'(RD_CYC - 1);
	localparam logic [2:0] WR_LOAD  = 3'(WR_CYC - 1);
	localparam logic [2:0] GAP_LOAD = 3'(GAP_CYC - 1);

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_READ,
		ST_SETUP,
		ST_WRITE,
		ST_HOLD,
		ST_GAP
	} bsc_state_e;

	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [14:0] addr;
		logic [7:0]  dout;
		logic        dout_oe;
	} bsc_pins_s;

	localparam bsc_pins_s PINS_IDLE = '{
		ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
		addr: 15'h0000, dout: 8'h00, dout_oe: 1'b0};

endpackage

// [logic/bsc_host_ctrl.sv]
// Purpose: Host-side controller driving a battery-backed byte-wide memory
// Assumes: PWR_OK_IN is a synchronous supply-good flag from a supervisor
// Notes:   One access at a time; request taken only while READY_OUT is high
//
// Summary of operation
// - Write while select and strobe both low
// - Write ends on first rising control edge
// - Host holds address and data stable
// - Host keeps controls high between cycles
// - Host keeps output enable high writing
`timescale 1ns/1ps
module bsc_host_ctrl #(
	parameter int unsigned REC_CYC = 10000 // Power-up recovery cycles
) (
	input  wire logic        CLK_IN,
	input  wire logic        NRST_IN,
	input  wire logic        CLK_EN_IN,
	input  wire logic        PWR_OK_IN,
	input  wire logic        REQ_IN,
	input  wire logic        WR_IN,
	input  wire logic [14:0] ADDR_IN,
	input  wire logic [7:0]  WDATA_IN,
	output logic             READY_OUT,
	output logic             DONE_OUT,
	output logic             ERR_OUT,
	output logic [7:0]       RDATA_OUT,
	output logic [14:0]      MEM_ADDR_OUT,
	output logic             MEM_CE_N_OUT,
	output logic             MEM_OE_N_OUT,
	output logic             MEM_WE_N_OUT,
	input  wire logic [7:0]  DATA_IN,
	output logic [7:0]       DATA_OUT,
	output logic             DATA_OE_OUT
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	bsc_pkg::bsc_state_e state_ff;
	bsc_pkg::bsc_state_e nxt_state;
	bsc_pkg::bsc_pins_s  pins_ff;
	bsc_pkg::bsc_pins_s  nxt_pins;
	logic [2:0]          cnt_ff;
	logic [2:0]          nxt_cnt;
	logic                done_ff;
	logic                nxt_done;
	logic                err_ff;
	logic                nxt_err;
	logic [7:0]          rdata_ff;
	logic [7:0]          nxt_rdata;
	logic [31:0]         rec_ff;
	logic [31:0]         nxt_rec;
	logic                ready_ff;
	logic                nxt_ready;
	logic                take;

	// Request accepted only when idle, powered and recovered
	assign take = REQ_IN && ready_ff && PWR_OK_IN;

	// ------------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------------
	// Next-state logic for pins and sequencing
	always_comb begin
		nxt_state = state_ff;
		nxt_pins  = pins_ff;
		nxt_cnt   = cnt_ff;
		nxt_done  = 1'b0;
		nxt_err   = 1'b0;
		nxt_rdata = rdata_ff;
		if (!PWR_OK_IN) begin
			// Drop all controls; a write in flight may spoil its byte
			nxt_pins  = bsc_pkg::PINS_IDLE;
			nxt_state = bsc_pkg::ST_IDLE;
			// A finished access waiting out its gap is not aborted
			if (state_ff != bsc_pkg::ST_IDLE &&
				state_ff != bsc_pkg::ST_GAP) begin
				nxt_done = 1'b1;
				nxt_err  = 1'b1;
			end
		end else begin
			case (state_ff)
				bsc_pkg::ST_IDLE: begin
					if (take) begin
						nxt_pins.addr = ADDR_IN;
						if (WR_IN) begin
							// Address and data settle before strobes
							nxt_pins.dout    = WDATA_IN;
							nxt_pins.dout_oe = 1'b1;
							nxt_state        = bsc_pkg::ST_SETUP;
						end else begin
							// Select and enable together; wait out access
							nxt_pins.ce_n = 1'b0;
							nxt_pins.oe_n = 1'b0;
							nxt_cnt       = bsc_pkg::RD_LOAD;
							nxt_state     = bsc_pkg::ST_READ;
						end
					end
				end
				bsc_pkg::ST_READ: begin
					if (cnt_ff == 3'h0) begin
						// Sample only after full access; early data is junk
						nxt_rdata     = DATA_IN;
						nxt_done      = 1'b1;
						nxt_pins.ce_n = 1'b1;
						nxt_pins.oe_n = 1'b1;
						nxt_cnt       = bsc_pkg::GAP_LOAD;
						nxt_state     = bsc_pkg::ST_GAP;
					end else begin
						nxt_cnt = cnt_ff - 3'h1;
					end
				end
				bsc_pkg::ST_SETUP: begin
					// Both fall on one edge so outputs never turn on
					nxt_pins.ce_n = 1'b0;
					nxt_pins.we_n = 1'b0;
					nxt_cnt       = bsc_pkg::WR_LOAD;
					nxt_state     = bsc_pkg::ST_WRITE;
				end
				bsc_pkg::ST_WRITE: begin
					if (cnt_ff == 3'h0) begin
						// Rising strobes end the write on held data
						nxt_pins.ce_n = 1'b1;
						nxt_pins.we_n = 1'b1;
						nxt_state     = bsc_pkg::ST_HOLD;
					end else begin
						nxt_cnt = cnt_ff - 3'h1;
					end
				end
				bsc_pkg::ST_HOLD: begin
					// One more cycle of data and address for hold
					nxt_pins.dout_oe = 1'b0;
					nxt_done         = 1'b1;
					nxt_cnt          = bsc_pkg::GAP_LOAD;
					nxt_state        = bsc_pkg::ST_GAP;
				end
				bsc_pkg::ST_GAP: begin
					// Controls stay high between accesses
					if (cnt_ff == 3'h0) begin
						nxt_state = bsc_pkg::ST_IDLE;
					end else begin
						nxt_cnt = cnt_ff - 3'h1;
					end
				end
				default: begin
					nxt_pins  = bsc_pkg::PINS_IDLE;
					nxt_state = bsc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Recovery counter restarts on every supply fault
	always_comb begin
		if (!PWR_OK_IN) begin
			nxt_rec = REC_CYC;
		end else if (rec_ff != 32'h0) begin
			nxt_rec = rec_ff - 32'h1;
		end else begin
			nxt_rec = rec_ff;
		end
		nxt_ready = (nxt_state == bsc_pkg::ST_IDLE) && PWR_OK_IN &&
			(nxt_rec == 32'h0);
	end

	// Sequencer and pin registers
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			state_ff <= bsc_pkg::ST_IDLE;
			pins_ff  <= bsc_pkg::PINS_IDLE;
			cnt_ff   <= 3'h0;
			done_ff  <= 1'b0;
			err_ff   <= 1'b0;
			rdata_ff <= 8'h00;
		end else if (CLK_EN_IN) begin
			state_ff <= nxt_state;
			pins_ff  <= nxt_pins;
			cnt_ff   <= nxt_cnt;
			done_ff  <= nxt_done;
			err_ff   <= nxt_err;
			rdata_ff <= nxt_rdata;
		end
	end

	// Power recovery; reset assumes the supply just came up
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rec_ff   <= REC_CYC;
			ready_ff <= 1'b0;
		end else if (CLK_EN_IN) begin
			rec_ff   <= nxt_rec;
			ready_ff <= nxt_ready;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from flops
	// ------------------------------------------------------------------
	assign READY_OUT    = ready_ff;
	assign DONE_OUT     = done_ff;
	assign ERR_OUT      = err_ff;
	assign RDATA_OUT    = rdata_ff;
	assign MEM_ADDR_OUT = pins_ff.addr;
	assign MEM_CE_N_OUT = pins_ff.ce_n;
	assign MEM_OE_N_OUT = pins_ff.oe_n;
	assign MEM_WE_N_OUT = pins_ff.we_n;
	assign DATA_OUT     = pins_ff.dout;
	assign DATA_OE_OUT  = pins_ff.dout_oe;

	// ------------------------------------------------------------------
	// Checks; frozen cycles are excluded
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN || !CLK_EN_IN);

	sequence s_wr_fall;
		$fell(pins_ff.we_n);
	endsequence
	sequence s_rd_start;
		take && !WR_IN;
	endsequence

	chk_oe_off_write: assert property (
		!pins_ff.we_n |-> pins_ff.oe_n)
		else $error("Output enable low during write");
	chk_joint_fall: assert property (
		s_wr_fall |-> $fell(pins_ff.ce_n))
		else $error("Strobe fell apart from select");
	chk_write_width: assert property (
		s_wr_fall ##0 PWR_OK_IN[*3] |-> !pins_ff.we_n
		##1 pins_ff.we_n)
		else $error("Write pulse not three cycles");
	chk_write_hold: assert property (
		$rose(pins_ff.we_n) && PWR_OK_IN |-> pins_ff.dout_oe
		&& $stable(pins_ff.addr) && $stable(pins_ff.dout))
		else $error("Data or address moved at write end");
	chk_addr_stable: assert property (
		!pins_ff.ce_n && !$fell(pins_ff.ce_n) |-> $stable(pins_ff.addr))
		else $error("Address changed during access");
	chk_gap_high: assert property (
		$rose(pins_ff.ce_n) |-> pins_ff.ce_n[*3])
		else $error("Select high gap too short");
	chk_fault_deselect: assert property (
		!PWR_OK_IN |=> pins_ff.ce_n && pins_ff.we_n && pins_ff.oe_n
		&& !pins_ff.dout_oe)
		else $error("Pins active after supply fault");
	chk_recovery_wait: assert property (
		$fell(pins_ff.ce_n) || $rose(pins_ff.dout_oe) |-> rec_ff == 32'h0)
		else $error("Access during recovery delay");
	chk_read_done: assert property (
		s_rd_start |-> ##[1:5] done_ff)
		else $error("Read did not complete in time");
	chk_read_sample: assert property (
		s_rd_start ##1 PWR_OK_IN[*4] |=> done_ff
		&& rdata_ff == $past(DATA_IN))
		else $error("Read data not sampled at access end");

endmodule

// [bench/bsc_mem_model.sv]
// Purpose: Behavioural byte-wide backed memory with mirrored clock bytes
// Assumes: Supply flag shared with the host; refresh strobe from the bench
// Notes:   Stale or floating data is shown inverted, never as a held value
`timescale 1ns/1ps
module bsc_mem_model #(
	parameter int REC_NS = 200 // Write lockout after power return
) (
	input  wire logic        tick_in,
	input  wire logic        pwr_ok_in,
	input  wire logic        ce_n_in,
	input  wire logic        oe_n_in,
	input  wire logic        we_n_in,
	input  wire logic [14:0] addr_in,
	input  wire logic [7:0]  dq_in,
	output logic [7:0]       dq_out,
	output logic             dq_oe_out
);
	logic [7:0]  mem [0:32767];
	logic [7:0]  cnt [0:6];
	logic [16:0] key_d;
	realtime     up_t = 0.0;
	wire  [16:0] key    = {addr_in, ce_n_in, oe_n_in};
	wire  [7:0]  ctl    = mem[bsc_pkg::CLK_CTRL_ADDR];
	wire         wr_act = pwr_ok_in && !ce_n_in && !we_n_in;

	// --------------------------------------------------------------
	// Read side
	// --------------------------------------------------------------
	// Inertial delay: any change restarts the access time
	assign #(bsc_pkg::RD_NS) key_d = key;
	assign dq_oe_out = pwr_ok_in && !ce_n_in && !oe_n_in && we_n_in;
	assign dq_out = (key_d === key) ? mem[addr_in] : ~mem[addr_in];

	// --------------------------------------------------------------
	// Write and refresh
	// --------------------------------------------------------------
	// Supply return time; writes stay blocked for the lockout after it
	always @(posedge pwr_ok_in) up_t = $realtime;

	// Byte taken at the first rising control edge, lost if supply fails
	always @(negedge wr_act) begin
		if (pwr_ok_in && !$isunknown(addr_in) &&
				$realtime - up_t >= REC_NS) begin
			if (addr_in == bsc_pkg::CLK_CTRL_ADDR && ctl[7] && !dq_in[7]) begin
				for (int i = 0; i < 7; i++)
					cnt[i] = mem[15'(bsc_pkg::CLK_SEC_ADDR + i)];
			end
			mem[addr_in] = dq_in;
		end
	end

	// Once-per-second copy, halted by either control bit
	always @(posedge tick_in) begin
		// Seconds count on in BCD; halting the copy leaves them running
		if (cnt[0][3:0] == 4'h9)
			cnt[0] = {cnt[0][7:4] + 4'h1, 4'h0};
		else
			cnt[0] = cnt[0] + 8'h01;
		if (!ctl[bsc_pkg::CTRL_READ_BIT] && !ctl[bsc_pkg::CTRL_WRITE_BIT]) begin
			for (int i = 0; i < 7; i++)
				if (!(wr_act && addr_in == 15'(bsc_pkg::CLK_SEC_ADDR + i)))
					mem[15'(bsc_pkg::CLK_SEC_ADDR + i)] = cnt[i];
		end
	end
endmodule

// [bench/battery_backed_sram_clock_port_bench.sv]
// Purpose: Self-checking bench for the backed memory host controller
// Assumes: Recovery count shortened to 20 cycles
// Notes:   Results noted in a queue and checked when DONE pulses
`timescale 1ns/1ps
module battery_backed_sram_clock_port_bench;
	typedef struct packed {logic rd; logic err; logic [7:0] val;} bsc_note_s;
	logic        clk = 1'b0, nrst = 1'b0, pwr = 1'b1, req = 1'b0;
	logic        wr = 1'b0, tick = 1'b0, cen = 1'b1;
	logic [14:0] addr = 15'h0000, adr [0:7];
	logic [7:0]  wdata = 8'h00, last = 8'h00, dq, dout, rdata;
	logic        dq_oe, d_oe, ready, done, err, ce_n, oe_n, we_n;
	logic [14:0] maddr;
	wire  [7:0]  bus = d_oe ? dout : (dq_oe ? dq : ~last);
	int          err_total, cmp_count, n;
	bsc_note_s   notes [$];
	bsc_note_s   nt;
	logic [7:0]  ref_m [int];
	localparam logic [14:0] SEC = bsc_pkg::CLK_SEC_ADDR;

	// Clock; floating bus shows a new pattern each cycle
	always #10 clk = ~clk;
	always @(posedge clk) last <= bus;

	bsc_host_ctrl #(.REC_CYC(20)) bsc_host_ctrl_i (.CLK_IN(clk),
		.NRST_IN(nrst), .CLK_EN_IN(cen), .PWR_OK_IN(pwr), .REQ_IN(req),
		.WR_IN(wr), .ADDR_IN(addr), .WDATA_IN(wdata), .READY_OUT(ready),
		.DONE_OUT(done), .ERR_OUT(err), .RDATA_OUT(rdata),
		.MEM_ADDR_OUT(maddr), .MEM_CE_N_OUT(ce_n), .MEM_OE_N_OUT(oe_n),
		.MEM_WE_N_OUT(we_n), .DATA_IN(bus), .DATA_OUT(dout),
		.DATA_OE_OUT(d_oe));
	bsc_mem_model bsc_mem_model_i (.tick_in(tick), .pwr_ok_in(pwr),
		.ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(maddr),
		.dq_in(bus), .dq_out(dq), .dq_oe_out(dq_oe));

	task automatic chk(input string what, input logic [7:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Drivers, all on the falling edge
	// --------------------------------------------------------------
	task automatic wait_rdy(output int c);
		c = 0;
		while (ready !== 1'b1 && c < 500) begin
			@(negedge clk);
			c++;
		end
		// A ready that never comes is a failure, not a skip
		if (ready !== 1'b1)
			err_total++;
	endtask

	task automatic acc(input logic w, input logic [14:0] a,
			input logic [7:0] d, input logic e);
		int c;
		wait_rdy(c);
		notes.push_back('{!w, e, w ? 8'h00 : ref_m[a]});
		if (w && !e)
			ref_m[a] = d;
		req = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		@(negedge clk);
		req = 1'b0;
	endtask

	task automatic pulse_tick;
		int c;
		wait_rdy(c);
		tick = 1'b1;
		@(negedge clk);
		tick = 1'b0;
	endtask

	// --------------------------------------------------------------
	// Result watcher and bus contention check
	// --------------------------------------------------------------
	// Looked at mid-cycle, clear of the edge that launches the outputs
	always @(negedge clk) begin
		if (done === 1'b1) begin
			nt = (notes.size() > 0) ? notes.pop_front() : 10'h3FF;
			chk("error flag", {7'h00, err}, {7'h00, nt.err});
			if (nt.rd)
				chk("read data", rdata, nt.val);
		end
		if (d_oe === 1'b1 && dq_oe === 1'b1)
			chk("bus contention", 8'h01, 8'h00);
	end

	// Watchdog well past the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		wrap_up();
	end

	initial begin
		void'($urandom(8));
		repeat (20) @(negedge clk);
		nrst = 1'b1;
		wait_rdy(n);
		chk("recovery", n[7:0], 8'h14);
		$display("Test reset done");
		// Random bytes below the clock area, both ends included
		for (int i = 0; i < 8; i++) begin
			adr[i] = (i == 0) ? 15'h0000 : (i == 7) ? 15'h7FF7
				: 15'($urandom % 32760);
			acc(1'b1, adr[i], 8'($urandom), 1'b0);
		end
		for (int i = 0; i < 8; i++) begin
			acc(1'b0, adr[i], 8'h00, 1'b0);
			if (i == 3) begin
				// Freeze mid-read, just after select falls; select must stay low
				cen = 1'b0;
				repeat (4) @(negedge clk);
				chk("frozen select", {7'h00, ce_n}, 8'h00);
				cen = 1'b1;
			end
		end
		$display("Test array done");
		// Set clock, overwrite copies, refresh restores copies from counters
		acc(1'b1, bsc_pkg::CLK_CTRL_ADDR, 8'h80, 1'b0);
		for (int i = 0; i < 7; i++)
			acc(1'b1, 15'(SEC + i), 8'(8'h10 + i), 1'b0);
		acc(1'b1, bsc_pkg::CLK_CTRL_ADDR, 8'h00, 1'b0);
		for (int i = 0; i < 7; i++)
			acc(1'b1, 15'(SEC + i), 8'hEE, 1'b0);
		pulse_tick();
		for (int i = 0; i < 7; i++) begin
			// Seconds moved on by one at the tick
			ref_m[15'(SEC + i)] = 8'(8'h10 + i + (i == 0));
			acc(1'b0, 15'(SEC + i), 8'h00, 1'b0);
		end
		// Read bit holds the copy still
		acc(1'b1, bsc_pkg::CLK_CTRL_ADDR, 8'h40, 1'b0);
		acc(1'b1, SEC, 8'h55, 1'b0);
		pulse_tick();
		acc(1'b0, SEC, 8'h00, 1'b0);
		$display("Test clock done");
		// Supply loss with strobes low, neighbour byte kept
		acc(1'b1, adr[1], 8'hA5, 1'b1);
		@(negedge clk);
		pwr = 1'b0;
		repeat (4) @(negedge clk);
		pwr = 1'b1;
		wait_rdy(n);
		chk("recovery after loss", n[7:0], 8'h14);
		acc(1'b0, adr[2], 8'h00, 1'b0);
		// First write after recovery must land
		acc(1'b1, adr[1], 8'h5A, 1'b0);
		acc(1'b0, adr[1], 8'h00, 1'b0);
		wait_rdy(n);
		chk("notes left", 8'(notes.size()), 8'h00);
		$display("Test supply done");
		wrap_up();
	end
endmodule
